// ==== core/enc_pkg.sv ====
// Purpose: shared constants and types for the angle encoder output logic
// Assumes: system clock at 20 MHz
// Notes:   pulse-width step given in time and in cycles, frame in steps
package enc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;
  // one pulse-width step per angle lsb, in ns
  localparam int unsigned PWM_STEP_NS   = 500;
  localparam int unsigned PWM_STEP_CYC  = PWM_STEP_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  STEP_LAST     = 4'(PWM_STEP_CYC - 1);
  // last step of one pulse-width frame (258 steps); low phase is at least two steps
  localparam logic [8:0]  FRAME_LAST    = 9'h101;

  localparam int unsigned ANGLE_W       = 8;
  localparam int unsigned TURN_W        = 8;
  localparam int unsigned WORD_W        = ANGLE_W + TURN_W;
  localparam logic [4:0]  WORD_BITS     = 5'h10;

  localparam logic [7:0]  ZERO_RST      = 8'h00;
  localparam logic [7:0]  ANGLE_RST     = 8'h00;
  localparam logic [7:0]  TURN_RST      = 8'h00;
  // quadrant bounds used to spot a wrap through zero
  localparam logic [7:0]  WRAP_HI       = 8'hC0;
  localparam logic [7:0]  WRAP_LO       = 8'h40;

  // word shifted out on the serial link, msb first
  typedef struct packed {
    logic [TURN_W-1:0]  turns;
    logic [ANGLE_W-1:0] angle;
  } snapshot_t;

endpackage

// ==== core/angle_encoder_output_logic.sv ====
// Purpose: pulse-width, serial, zero, turn count and wake logic of encoder
// Assumes: rawAngle, zeroStore, supplyOff, pollingMode on clk_sys;
//          fieldWeak from the analog side, asynchronous
// Notes:   serial logic runs on serialClockIn, frame held by selectIn
`timescale 1ns/1ps

// Function
// R1 - angle reported as an absolute 8-bit value, 256 positions per turn
// R2 - pulse-width output grows by 0.5us per angle lsb
// R3 - field_low_flag high while field too weak, low otherwise
// R4 - host holds select_in high to address device; active high
// R5 - in polling mode, open-drain wake output asserts on position change
// R6 - full revolutions counted, readable alongside the angle
// R7 - any magnet position can be stored as zero position
// R8 - last angle kept in storage register while main supply is off
// R9 - host clocks serial transfers; data moves on serial_data_io
// R10 - reported angle is raw minus zero position, modulo 256
module angle_encoder_output_logic (
  // system
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // front end
  input  wire logic [7:0] rawAngle,
  input  wire logic       fieldWeak,
  input  wire logic       zeroStore,
  input  wire logic       supplyOff,
  input  wire logic       pollingMode,
  // status pins
  output logic            fieldLowFlag,
  output logic            pwmOut,
  output logic            motionWakeOut,
  output logic            motionWakeOe,
  // serial link
  input  wire logic       serialClockIn,
  input  wire logic       selectIn,
  input  wire logic       serialDataIn,
  output logic            serialDataOut,
  output logic            serialDataOe
);

  logic [7:0]         zeroPos_r;
  logic [7:0]         angleHold_r;
  logic [7:0]         prevAngle_r;
  logic [7:0]         turnCount_r;
  logic [2:0]         fieldSync_r;
  logic [1:0]         selSync_r;
  logic               selSeen_r;
  logic               wakePend_r;
  logic [3:0]         stepCnt_r;
  logic [8:0]         slot_r;
  logic [7:0]         pwmAngle_r;
  logic               pwmOut_r;
  enc_pkg::snapshot_t snap_r;

  wire logic [7:0] relAngle  = rawAngle - zeroPos_r; // R10
  wire logic       fwdWrap   = (prevAngle_r >= enc_pkg::WRAP_HI) &&
                               (angleHold_r < enc_pkg::WRAP_LO);
  wire logic       revWrap   = (prevAngle_r < enc_pkg::WRAP_LO) &&
                               (angleHold_r >= enc_pkg::WRAP_HI);
  wire logic       moved     = angleHold_r != prevAngle_r;
  wire logic       selSys    = selSync_r[1];
  wire logic       readStart = selSys && !selSeen_r;
  wire logic       stepEnd   = stepCnt_r == enc_pkg::STEP_LAST;
  wire logic       frameEnd  = stepEnd && (slot_r == enc_pkg::FRAME_LAST);

  // zero position and held angle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      zeroPos_r   <= enc_pkg::ZERO_RST;
      angleHold_r <= enc_pkg::ANGLE_RST;
      prevAngle_r <= enc_pkg::ANGLE_RST;
    end else begin
      if (zeroStore) begin
        zeroPos_r <= rawAngle; // R7
      end
      if (!supplyOff) begin
        angleHold_r <= relAngle; // R8
      end
      prevAngle_r <= angleHold_r;
    end
  end

  // revolution counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      turnCount_r <= enc_pkg::TURN_RST;
    end else if (fwdWrap) begin
      turnCount_r <= turnCount_r + 8'h01; // R6
    end else if (revWrap) begin
      turnCount_r <= turnCount_r - 8'h01; // R6
    end
  end

  // field flag and select synchronisers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fieldSync_r <= 3'h0;
      selSync_r   <= 2'h0;
      selSeen_r   <= 1'b0;
    end else begin
      fieldSync_r <= {fieldSync_r[1:0], fieldWeak}; // R3
      selSync_r   <= {selSync_r[0], selectIn};
      selSeen_r   <= selSys;
    end
  end
  assign fieldLowFlag = fieldSync_r[2]; // R3

  // wake request: a new move wins over the clear by a read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wakePend_r <= 1'b0;
    end else if (pollingMode && moved) begin
      wakePend_r <= 1'b1; // R5
    end else if (!pollingMode || readStart) begin
      wakePend_r <= 1'b0;
    end
  end
  // open drain: only ever pulls low
  assign motionWakeOut = 1'b0;
  assign motionWakeOe  = wakePend_r; // R5

  // snapshot frozen while a frame is open
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      snap_r <= '0;
    end else if (!selSys) begin
      snap_r <= '{turns: turnCount_r, angle: angleHold_r}; // R1 R6
    end
  end

  // pulse-width generator
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stepCnt_r  <= 4'h0;
      slot_r     <= 9'h000;
      pwmAngle_r <= enc_pkg::ANGLE_RST;
      pwmOut_r   <= 1'b0;
    end else begin
      stepCnt_r <= stepEnd ? 4'h0 : stepCnt_r + 4'h1;
      if (frameEnd) begin
        slot_r     <= 9'h000;
        pwmAngle_r <= angleHold_r;
      end else if (stepEnd) begin
        slot_r <= slot_r + 9'h001;
      end
      pwmOut_r <= (slot_r <= {1'b0, pwmAngle_r}); // R2
    end
  end
  assign pwmOut = pwmOut_r;

  // serial link domain, held in reset outside a frame
  logic        loaded_r;
  logic [15:0] shift_r;
  logic        dataOut_r;
  wire logic   linkRst_n = reset_n && selectIn; // R4

  always_ff @(posedge serialClockIn or negedge linkRst_n) begin
    if (!linkRst_n) begin
      loaded_r  <= 1'b0;
      shift_r   <= 16'h0000;
      dataOut_r <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r  <= 1'b1;
      shift_r   <= {snap_r[14:0], 1'b0}; // R9
      dataOut_r <= snap_r[15];
    end else begin
      shift_r   <= {shift_r[14:0], 1'b0};
      dataOut_r <= shift_r[15]; // R9
    end
  end
  assign serialDataOut = dataOut_r;
  assign serialDataOe  = selectIn; // R9

  // assertion helpers
  logic [12:0] highCnt_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      highCnt_r <= 13'h0000;
    end else begin
      highCnt_r <= pwmOut_r ? highCnt_r + 13'h0001 : 13'h0000;
    end
  end
  wire logic [12:0] pwmWant =
    13'(({5'h00, pwmAngle_r} + 13'h0001) * enc_pkg::PWM_STEP_CYC);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_wrap_fwd;
    fwdWrap ##1 1'b1;
  endsequence

  a_zero_store: assert property ( // R7
    zeroStore |=> zeroPos_r == $past(rawAngle))
    else $error("zero position not stored");
  a_rel_angle: assert property ( // R10
    !supplyOff |=> angleHold_r == $past(relAngle))
    else $error("reported angle not raw minus zero");
  a_hold_off: assert property ( // R8
    supplyOff |=> angleHold_r == $past(angleHold_r))
    else $error("held angle changed with supply off");
  a_field_flag: assert property ( // R3
    fieldWeak ##1 fieldWeak ##1 fieldWeak |=> fieldLowFlag)
    else $error("field flag missed weak field");
  a_wake_move: assert property ( // R5
    pollingMode && moved |=> motionWakeOe && !motionWakeOut)
    else $error("wake not raised on motion");
  a_turn_up: assert property ( // R6
    s_wrap_fwd |-> turnCount_r == $past(turnCount_r) + 8'h01)
    else $error("revolution not counted");
  a_pwm_width: assert property ( // R2
    $fell(pwmOut_r) |-> highCnt_r == pwmWant)
    else $error("pulse width not angle steps");
  a_snap_angle: assert property ( // R1
    !selSys |=> snap_r.angle == $past(angleHold_r))
    else $error("snapshot angle stale");
  a_serial_first: assert property ( // R9
    @(posedge serialClockIn) disable iff (!linkRst_n)
    !loaded_r |=> loaded_r && dataOut_r == $past(snap_r[15]))
    else $error("first serial bit wrong");

endmodule

// ==== test/host_model.sv ====
// Purpose: host side reading the serial word and the wake line
// Assumes: link clock 80 ns, runs only while selected
// Notes:   released data line shows inverse of last bit
`timescale 1ns/1ps
module host_model (
  // serial link
  output logic      serialClockIn,
  output logic      selectIn,
  output logic      serialDataIn,
  input  wire logic serialDataOut,
  input  wire logic serialDataOe,
  // wake
  input  wire logic motionWakeOe,
  output logic      wakeLine
);
  logic lastBit = 1'b0;
  assign serialDataIn = serialDataOe ? serialDataOut : ~lastBit;
  // pull-up on the open-drain wake line
  assign wakeLine = motionWakeOe ? 1'b0 : 1'b1;
  initial begin
    serialClockIn = 1'b0;
    selectIn = 1'b0;
  end
  task automatic read_word(output logic [15:0] w);
    selectIn = 1'b1;
    #200;
    for (int i = 15; i >= 0; i--) begin
      serialClockIn = 1'b1;
      #40;
      w[i] = serialDataIn;
      lastBit = serialDataIn;
      serialClockIn = 1'b0;
      #40;
    end
    selectIn = 1'b0;
    #400;
  endtask
endmodule

// ==== test/test_angle_encoder_output_logic.sv ====
// Purpose: self-checking bench for angle encoder output logic
// Assumes: clk_sys 50 ns, link clock made by the host model
// Notes:   expectations from zero offset, wrap and step rules
`timescale 1ns/1ps
module test_angle_encoder_output_logic;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  rawAngle = 8'h00;
  logic        fieldWeak = 1'b0;
  logic        zeroStore = 1'b0;
  logic        supplyOff = 1'b0;
  logic        pollingMode = 1'b0;
  logic        fieldLowFlag, pwmOut, motionWakeOut, motionWakeOe;
  logic        serialClockIn, selectIn, serialDataIn, serialDataOut;
  logic        serialDataOe, wakeLine;
  logic [15:0] word;
  int          err_count = 0;
  int          total_checks = 0;

  always #25 clk_sys = ~clk_sys;

  angle_encoder_output_logic i_dut (.clk_sys, .reset_n, .rawAngle,
    .fieldWeak, .zeroStore, .supplyOff, .pollingMode, .fieldLowFlag,
    .pwmOut, .motionWakeOut, .motionWakeOe, .serialClockIn, .selectIn,
    .serialDataIn, .serialDataOut, .serialDataOe);
  host_model i_host (.serialClockIn, .selectIn, .serialDataIn,
    .serialDataOut, .serialDataOe, .motionWakeOe, .wakeLine);

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic rd();
    i_host.read_word(word);
    step(1);
    chk(16'({serialDataOe, motionWakeOut}), 16'h0000);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_zero();
    rawAngle = 8'h10;
    zeroStore = 1'b1;
    step(1);
    zeroStore = 1'b0;
    rawAngle = 8'h90;
    step(4);
    rd();
    chk(word, 16'h0080);
    $display("test zero done");
  endtask
  task automatic t_turns();
    rawAngle = 8'hD0;
    step(2);
    rawAngle = 8'h20;
    step(4);
    rd();
    chk(word, 16'h0110);
    rawAngle = 8'hD0;
    step(4);
    rd();
    chk(word, 16'h00C0);
    $display("test turns done");
  endtask
  task automatic t_hold();
    supplyOff = 1'b1;
    rawAngle = 8'h50;
    step(4);
    rd();
    chk(word, 16'h00C0);
    supplyOff = 1'b0;
    step(4);
    rd();
    chk(word, 16'h0040);
    $display("test hold done");
  endtask
  task automatic t_field();
    fieldWeak = 1'b1;
    step(4);
    chk(16'(fieldLowFlag), 16'h0001);
    fieldWeak = 1'b0;
    step(4);
    chk(16'(fieldLowFlag), 16'h0000);
    $display("test field done");
  endtask
  task automatic t_wake();
    pollingMode = 1'b1;
    step(4);
    chk(16'(wakeLine), 16'h0001);
    rawAngle = 8'h58;
    step(3);
    chk(16'(wakeLine), 16'h0000);
    rd();
    chk(16'(wakeLine), 16'h0001);
    chk(word, 16'h0048);
    pollingMode = 1'b0;
    $display("test wake done");
  endtask
  task automatic t_pwm();
    int n;
    n = 0;
    // third pulse carries the settled angle 0x48
    for (int f = 0; f < 3; f++) begin
      n = 0;
      while (pwmOut !== 1'b1 && n < 3000) begin
        step(1);
        n++;
      end
      n = 0;
      while (pwmOut === 1'b1 && n < 3000) begin
        step(1);
        n++;
      end
    end
    chk(16'(n), 16'h02DA);
    $display("test pwm done");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #5;
    reset_n = 1'b1;
    step(2);
    t_zero();
    t_turns();
    t_hold();
    t_field();
    t_wake();
    t_pwm();
    results();
  end
  initial begin
    #3000000;
    err_count++;
    results();
  end
endmodule
